/* core/abl_map.svh */
// Offsets, field positions, reset values and encodings for the atomic byte and twin word load block
`ifndef ABL_MAP_SVH
`define ABL_MAP_SVH

`define ABL_OP_MEM        2'h3
`define ABL_OPS_BYTE_SET  6'h1D
`define ABL_OPS_TWIN_LOAD 6'h03

`define ABL_ASI_KERNEL       8'h04
`define ABL_ASI_KERNEL_LE    8'h0C
`define ABL_ASI_UVIEW_PRI    8'h10
`define ABL_ASI_UVIEW_SEC    8'h11
`define ABL_ASI_UVIEW_PRI_LE 8'h18
`define ABL_ASI_UVIEW_SEC_LE 8'h19
`define ABL_ASI_REAL         8'h14
`define ABL_ASI_REAL_LE      8'h1C
`define ABL_ASI_PRIMARY      8'h80
`define ABL_ASI_SECONDARY    8'h81
`define ABL_ASI_PRIMARY_LE   8'h88
`define ABL_ASI_SECONDARY_LE 8'h89
`define ABL_ASI_IMPLICIT     8'h80
`define ABL_ASI_IMPLICIT_LE  8'h88
`define ABL_ASI_LE_BIT       3
`define ABL_ASI_RESTR_LO     8'h30
`define ABL_ASI_RESTR_HI     8'h7F

`define ABL_OFS_CTRL       12'h000
`define ABL_OFS_ASI        12'h004
`define ABL_OFS_STATUS     12'h008
`define ABL_OFS_TRAP_COUNT 12'h00C

`define ABL_CTRL_SUPER   0
`define ABL_CTRL_HYPER   1
`define ABL_CTRL_TWIN_HW 2
`define ABL_CTRL_LE      3
`define ABL_CTRL_RESET   4'h4
`define ABL_ASI_RESET    8'h80
`define ABL_STAT_BUSY    8

`define ABL_BYTE_ONES 8'hFF
`define ABL_SIZE_BYTE 1'b0
`define ABL_SIZE_DWRD 1'b1

`endif

/* core/abl_pkg.sv */
// Types for the atomic byte and twin word load block
package abl_pkg;

	typedef enum logic [2:0] {
		ABL_TRAP_NONE,
		ABL_TRAP_ILLEGAL,
		ABL_TRAP_PRIV_ACTION,
		ABL_TRAP_INVALID_SPACE,
		ABL_TRAP_MISALIGNED,
		ABL_TRAP_UNIMPL_TWIN
	} abl_trap_t;

	typedef enum logic [2:0] {
		ABL_ST_IDLE,
		ABL_ST_READ,
		ABL_ST_WRITE,
		ABL_ST_WB_EVEN,
		ABL_ST_WB_ODD
	} abl_state_t;

endpackage : abl_pkg

/* core/abl_top.sv */
// Decode and execution of the atomic byte-set load and the twin-word load, with an APB control slave
// Notes on behaviour
// [RL1] Decode byte-set from memory opcode, subfield 1D
// [RL2] Read byte, then write all ones
// [RL3] Fetched byte right-justified, upper bits zero
// [RL4] Read and write indivisible, no interrupts
// [RL5] Same-doubleword atomics complete serially
// [RL6] Space from instruction field or register
// [RL7] Unprivileged with space bit7 clear traps
// [RL8] Supervisor with space 30..7F traps
// [RL9] Only listed spaces, else invalid-space trap
// [RL10] Byte-set address: a+b or a+imm
// [RL11] Decode twin load, subfield 03
// [RL12] Two words to even/odd, upper zeroed
// [RL13] Destination zero updates only register one
// [RL14] Twin address a+b or a+imm, implicit space
// [RL15] Little-endian swaps each word separately
// [RL16] Odd destination gives illegal instruction
// [RL17] Register form with bits 12:5 set illegal
// [RL18] Address not 8-aligned gives misalignment
// [RL19] Twin load is one indivisible access
// [RL20] Unimplemented twin load traps for emulation
// [RL21] Producer keeps destination lsb zero
// [RL22] Decode traps win over misalignment
`timescale 1ns/1ps
`default_nettype none
`include "abl_map.svh"

module abl_top
	import abl_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr_word,
	input  wire logic [63:0] src_a_val,
	input  wire logic [63:0] src_b_val,
	output logic             instr_ready,
	output logic             irq_hold,
	output logic             mem_req,
	output logic             mem_we,
	output logic             mem_lock,
	output logic             mem_size,
	output logic      [63:0] mem_addr,
	output logic       [7:0] mem_asi,
	output logic      [63:0] mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [63:0] mem_rdata,
	output logic             wb_valid,
	output logic       [4:0] wb_reg,
	output logic      [63:0] wb_data,
	output logic             trap_valid,
	output logic       [2:0] trap_code
);

	typedef struct packed {
		abl_state_t  st;
		logic [3:0]  ctrl;
		logic [7:0]  asi_reg;
		abl_trap_t   last_trap;
		logic [15:0] trap_count;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        instr_ready;
		logic        irq_hold;
		logic        mem_req;
		logic        mem_we;
		logic        mem_lock;
		logic        mem_size;
		logic [63:0] mem_addr;
		logic [7:0]  mem_asi;
		logic [63:0] mem_wdata;
		logic [4:0]  rd;
		logic        le;
		logic [63:0] rdata;
		logic        wb_valid;
		logic [4:0]  wb_reg;
		logic [63:0] wb_data;
		logic        trap_valid;
		logic [2:0]  trap_code;
	} abl_regs_t;

	abl_regs_t r;
	abl_regs_t next_r;

	function automatic logic [31:0] swap32(input logic [31:0] w);
		swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : swap32

	function automatic logic space_ok(input logic [7:0] a);
		case (a)
			`ABL_ASI_KERNEL, `ABL_ASI_KERNEL_LE,
			`ABL_ASI_UVIEW_PRI, `ABL_ASI_UVIEW_PRI_LE,
			`ABL_ASI_UVIEW_SEC, `ABL_ASI_UVIEW_SEC_LE,
			`ABL_ASI_REAL, `ABL_ASI_REAL_LE,
			`ABL_ASI_PRIMARY, `ABL_ASI_PRIMARY_LE,
			`ABL_ASI_SECONDARY, `ABL_ASI_SECONDARY_LE: space_ok = 1'b1;
			default: space_ok = 1'b0;
		endcase
	endfunction : space_ok

	// Instruction fields
	logic [1:0]  opcode_major;
	logic [5:0]  opcode_subfield;
	logic [4:0]  dest_reg;
	logic        imm_sel;
	logic [7:0]  imm_space;
	logic [63:0] signed_imm_13;
	logic [63:0] eff_addr;
	logic [7:0]  sel_space;
	logic        is_byte_set;
	logic        is_twin;
	logic        supervisor_flag;
	logic        hypervisor_flag;
	logic        apb_hit;
	logic        take;
	abl_trap_t   dec_trap;

	assign opcode_major    = instr_word[31:30];
	assign opcode_subfield = instr_word[24:19];
	assign dest_reg        = instr_word[29:25];
	assign imm_sel         = instr_word[13];
	assign imm_space       = instr_word[12:5];
	assign signed_imm_13   = {{51{instr_word[12]}}, instr_word[12:0]};
	assign supervisor_flag = r.ctrl[`ABL_CTRL_SUPER];
	assign hypervisor_flag = r.ctrl[`ABL_CTRL_HYPER];
	assign is_byte_set = (opcode_major == `ABL_OP_MEM) && (opcode_subfield == `ABL_OPS_BYTE_SET); // RL1
	assign is_twin = (opcode_major == `ABL_OP_MEM) && (opcode_subfield == `ABL_OPS_TWIN_LOAD); // RL11
	assign eff_addr = src_a_val + (imm_sel ? signed_imm_13 : src_b_val); // RL10 RL14
	assign sel_space = imm_sel ? r.asi_reg : imm_space; // RL6
	assign take = instr_valid && r.instr_ready && (is_byte_set || is_twin);

	// Decode-time checks come first so they mask misalignment
	always_comb begin
		dec_trap = ABL_TRAP_NONE;
		if (is_twin) begin
			if (!r.ctrl[`ABL_CTRL_TWIN_HW]) begin
				dec_trap = ABL_TRAP_UNIMPL_TWIN; // RL20
			end else if (dest_reg[0]) begin
				dec_trap = ABL_TRAP_ILLEGAL; // RL16
			end else if (!imm_sel && (imm_space != 8'h00)) begin
				dec_trap = ABL_TRAP_ILLEGAL; // RL17
			end else if (eff_addr[2:0] != 3'h0) begin
				dec_trap = ABL_TRAP_MISALIGNED; // RL18 RL22
			end
		end else if (is_byte_set) begin
			if (!supervisor_flag && !hypervisor_flag && !sel_space[7]) begin
				dec_trap = ABL_TRAP_PRIV_ACTION; // RL7
			end else if (supervisor_flag && !hypervisor_flag && (sel_space >= `ABL_ASI_RESTR_LO)
				&& (sel_space <= `ABL_ASI_RESTR_HI)) begin
				dec_trap = ABL_TRAP_PRIV_ACTION; // RL8
			end else if (!space_ok(sel_space)) begin
				dec_trap = ABL_TRAP_INVALID_SPACE; // RL9
			end
		end
	end

	assign apb_hit = (paddr == `ABL_OFS_CTRL) || (paddr == `ABL_OFS_ASI)
		|| (paddr == `ABL_OFS_STATUS) || (paddr == `ABL_OFS_TRAP_COUNT);

	always_comb begin
		next_r = r;
		next_r.wb_valid = 1'b0;
		next_r.trap_valid = 1'b0;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;

		// APB: answer one cycle into the access phase
		if (psel && penable && !r.pready) begin
			next_r.pready = 1'b1;
			next_r.pslverr = !apb_hit;
			next_r.prdata = 32'h0000_0000;
			if (pwrite) begin
				if (paddr == `ABL_OFS_CTRL) begin
					next_r.ctrl = pwdata[3:0];
				end
				if (paddr == `ABL_OFS_ASI) begin
					next_r.asi_reg = pwdata[7:0];
				end
			end else begin
				case (paddr)
					`ABL_OFS_CTRL: next_r.prdata = {28'h0000000, r.ctrl};
					`ABL_OFS_ASI: next_r.prdata = {24'h000000, r.asi_reg};
					`ABL_OFS_STATUS: next_r.prdata = {23'h000000, r.irq_hold, 5'h00, r.last_trap};
					`ABL_OFS_TRAP_COUNT: next_r.prdata = {16'h0000, r.trap_count};
					default: next_r.prdata = 32'h0000_0000;
				endcase
			end
		end

		case (r.st)
			ABL_ST_IDLE: begin
				if (take) begin
					next_r.rd = dest_reg;
					next_r.last_trap = dec_trap;
					if (dec_trap != ABL_TRAP_NONE) begin
						next_r.trap_valid = 1'b1;
						next_r.trap_code = dec_trap;
						next_r.trap_count = r.trap_count + 16'h0001;
					end else begin
						// Interrupts held off for the whole sequence
						next_r.instr_ready = 1'b0;
						next_r.irq_hold = 1'b1; // RL4
						next_r.mem_req = 1'b1;
						next_r.mem_we = 1'b0;
						next_r.mem_addr = eff_addr;
						if (is_byte_set) begin
							next_r.mem_asi = sel_space;
							next_r.mem_size = `ABL_SIZE_BYTE;
							next_r.mem_lock = 1'b1; // RL4 RL5
						end else begin
							next_r.mem_asi = r.ctrl[`ABL_CTRL_LE] ? `ABL_ASI_IMPLICIT_LE : `ABL_ASI_IMPLICIT; // RL14
							next_r.mem_size = `ABL_SIZE_DWRD; // RL19
							next_r.mem_lock = 1'b0;
						end
						next_r.le = is_twin && r.ctrl[`ABL_CTRL_LE];
						next_r.st = ABL_ST_READ;
					end
				end
			end
			ABL_ST_READ: begin
				if (mem_ack) begin
					next_r.rdata = mem_rdata;
					if (r.mem_size == `ABL_SIZE_BYTE) begin
						// Lock stays up so no other master gets between read and write
						next_r.mem_we = 1'b1; // RL2
						next_r.mem_wdata = {56'h0, `ABL_BYTE_ONES}; // RL2
						next_r.st = ABL_ST_WRITE;
					end else begin
						next_r.mem_req = 1'b0;
						next_r.st = (r.rd == 5'h00) ? ABL_ST_WB_ODD : ABL_ST_WB_EVEN; // RL13
					end
				end
			end
			ABL_ST_WRITE: begin
				if (mem_ack) begin
					next_r.mem_req = 1'b0;
					next_r.mem_we = 1'b0;
					next_r.mem_lock = 1'b0;
					next_r.wb_valid = 1'b1;
					next_r.wb_reg = r.rd;
					next_r.wb_data = {56'h0, r.rdata[7:0]}; // RL3
					next_r.instr_ready = 1'b1;
					next_r.irq_hold = 1'b0;
					next_r.st = ABL_ST_IDLE;
				end
			end
			ABL_ST_WB_EVEN: begin
				next_r.wb_valid = 1'b1;
				next_r.wb_reg = r.rd;
				next_r.wb_data = {32'h0, r.le ? swap32(r.rdata[63:32]) : r.rdata[63:32]}; // RL12 RL15
				next_r.st = ABL_ST_WB_ODD;
			end
			ABL_ST_WB_ODD: begin
				next_r.wb_valid = 1'b1;
				next_r.wb_reg = {r.rd[4:1], 1'b1}; // RL21
				next_r.wb_data = {32'h0, r.le ? swap32(r.rdata[31:0]) : r.rdata[31:0]}; // RL12 RL15
				next_r.instr_ready = 1'b1;
				next_r.irq_hold = 1'b0;
				next_r.st = ABL_ST_IDLE;
			end
			default: begin
				next_r.st = ABL_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			r <= '0;
			r.st <= ABL_ST_IDLE;
			r.ctrl <= `ABL_CTRL_RESET;
			r.asi_reg <= `ABL_ASI_RESET;
			r.last_trap <= ABL_TRAP_NONE;
			r.instr_ready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign prdata      = r.prdata;
	assign pready      = r.pready;
	assign pslverr     = r.pslverr;
	assign instr_ready = r.instr_ready;
	assign irq_hold    = r.irq_hold;
	assign mem_req     = r.mem_req;
	assign mem_we      = r.mem_we;
	assign mem_lock    = r.mem_lock;
	assign mem_size    = r.mem_size;
	assign mem_addr    = r.mem_addr;
	assign mem_asi     = r.mem_asi;
	assign mem_wdata   = r.mem_wdata;
	assign wb_valid    = r.wb_valid;
	assign wb_reg      = r.wb_reg;
	assign wb_data     = r.wb_data;
	assign trap_valid  = r.trap_valid;
	assign trap_code   = r.trap_code;

endmodule : abl_top

`default_nettype wire

/* tb/abl_top_sva.sv */
// Port assertions for the byte-set and twin-word load block
`timescale 1ns/1ps
`default_nettype none

module abl_top_sva (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic        instr_ready,
	input wire logic        irq_hold,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic        mem_lock,
	input wire logic        mem_size,
	input wire logic [63:0] mem_addr,
	input wire logic  [7:0] mem_asi,
	input wire logic [63:0] mem_wdata,
	input wire logic        mem_ack,
	input wire logic        wb_valid,
	input wire logic [63:0] wb_data,
	input wire logic        trap_valid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_take;
		instr_valid && instr_ready && instr_word[31:30] == 2'h3
			&& (instr_word[24:19] == 6'h1D || instr_word[24:19] == 6'h03);
	endsequence
	sequence s_bset_write;
		mem_req && mem_we && mem_lock && !mem_size && mem_wdata[7:0] == 8'hFF;
	endsequence
	a_take_answer: assert property (s_take |=> trap_valid || mem_req)
		else $error("accepted instruction not answered");
	a_bset_read: assert property ($rose(mem_req) && !mem_size |-> !mem_we && mem_lock)
		else $error("byte-set must read first under lock");
	a_lock_pair: assert property (mem_lock && mem_ack && !mem_we |=> s_bset_write)
		else $error("byte-set write of ones not next");
	a_irq_hold: assert property (mem_req |-> irq_hold)
		else $error("interrupts open during access");
	a_twin_access: assert property (mem_req && mem_size |-> mem_addr[2:0] == 3'h0 && !mem_we
		&& mem_asi inside {8'h80, 8'h88}) else $error("bad twin access");
	a_wb_upper: assert property (wb_valid |-> wb_data[63:32] == 32'h0)
		else $error("upper half not zero");
	a_twin_wb: assert property (mem_size && mem_ack |=> !mem_req ##1 wb_valid)
		else $error("twin write-back late");
	a_bset_wb: assert property (mem_we && mem_ack |=> wb_valid && !mem_lock && wb_data[63:8] == 56'h0)
		else $error("byte-set result wrong");
endmodule : abl_top_sva

bind abl_top abl_top_sva chk_u (.clk_sys, .rst_b, .instr_valid, .instr_word, .instr_ready, .irq_hold, .mem_req,
	.mem_we, .mem_lock, .mem_size, .mem_addr, .mem_asi, .mem_wdata, .mem_ack, .wb_valid, .wb_data, .trap_valid);

`default_nettype wire

/* tb/abl_mem_model.sv */
// Behavioural memory behind the load/store path
`timescale 1ns/1ps
`default_nettype none

module abl_mem_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic        mem_size,
	input  wire logic [63:0] mem_addr,
	input  wire logic [63:0] mem_wdata,
	output logic             mem_ack,
	output logic      [63:0] mem_rdata
);
	logic [7:0]  mem [logic [63:0]];
	logic [63:0] d;
	int          cnt;
	function automatic logic [7:0] rdb(logic [63:0] y);
		return mem.exists(y) ? mem[y] : y[7:0] ^ 8'h5A;
	endfunction : rdb
	initial begin
		mem_ack = 1'b0;
		mem_rdata = '0;
		cnt = 0;
	end
	// Single port: a locked pair is never split by other traffic
	always @(posedge clk_sys) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata; // Inverts each cycle every bit that a read answer does not load, so stale data never holds steady
		if (!rst_b || !mem_req || mem_ack)
			cnt <= 0;
		else if (cnt < (slow ? 3 : 0))
			cnt <= cnt + 1;
		else begin
			mem_ack <= 1'b1;
			if (mem_we)
				mem[mem_addr] = mem_wdata[7:0];
			else if (mem_size) begin
				for (int k = 0; k < 8; k++)
					d[63 - 8 * k -: 8] = rdb({mem_addr[63:3], 3'h0} + k);
				mem_rdata <= d;
			end else
				mem_rdata <= {~mem_rdata[63:8], rdb(mem_addr)};
		end
	end
endmodule : abl_mem_model

`default_nettype wire

/* tb/test_atomic_byte_and_twin_word_load.sv */
// Self-checking testbench for the byte-set and twin-word load block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t got %0h want %0h", $time, a, b); end end

module test_atomic_byte_and_twin_word_load;
	logic        clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instr_valid = 1'b0;
	logic        slow = 1'b0, pready, pslverr, instr_ready, irq_hold, mem_req, mem_we, mem_lock, mem_size;
	logic        mem_ack, wb_valid, trap_valid, re, ok;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, instr_word = '0, rq;
	logic [63:0] src_a_val = '0, src_b_val = '0, mem_addr, mem_wdata, mem_rdata, wb_data, xa;
	logic [7:0]  mem_asi, xs, asi_r = 8'h80, mem [logic [63:0]];
	logic [7:0]  at [17] = '{8'h04, 8'h0C, 8'h10, 8'h11, 8'h18, 8'h19, 8'h14, 8'h1C, 8'h80, 8'h81, 8'h88, 8'h89,
		8'h30, 8'h7F, 8'h2F, 8'h00, 8'hFE};
	logic [4:0]  wb_reg;
	logic [2:0]  trap_code, seen, et, last = 3'h0;
	logic [3:0]  ctrl = 4'h4;
	logic [15:0] lf = 16'h7B63, r, r2;
	logic [36:0] q [$];
	int          err_count = 0, compares = 0, tcnt = 0;

	abl_top dut_u (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.instr_valid, .instr_word, .src_a_val, .src_b_val, .instr_ready, .irq_hold, .mem_req, .mem_we, .mem_lock,
		.mem_size, .mem_addr, .mem_asi, .mem_wdata, .mem_ack, .mem_rdata, .wb_valid, .wb_reg, .wb_data,
		.trap_valid, .trap_code);
	abl_mem_model mem_u (.clk_sys, .rst_b, .slow, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata);

	always #5 clk_sys = ~clk_sys;

	function automatic logic [15:0] lfsr();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : lfsr
	function automatic logic [7:0] rdb(logic [63:0] y);
		return mem.exists(y) ? mem[y] : y[7:0] ^ 8'h5A;
	endfunction : rdb
	function automatic logic [31:0] wd(logic [63:0] x, logic le);
		return le ? {rdb(x + 3), rdb(x + 2), rdb(x + 1), rdb(x)} : {rdb(x), rdb(x + 1), rdb(x + 2), rdb(x + 3)};
	endfunction : wd

	task automatic complete_run();
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic predict(logic [31:0] iw, logic [63:0] a, logic [63:0] b);
		logic [63:0] ea;
		logic [7:0]  s;
		ea = a + (iw[13] ? {{51{iw[12]}}, iw[12:0]} : b);
		s = iw[13] ? asi_r : iw[12:5];
		xa = ea;
		xs = (iw[24:19] == 6'h03) ? (ctrl[3] ? 8'h88 : 8'h80) : s;
		ok = 1'b0;
		for (int k = 0; k < 12; k++)
			ok |= s == at[k];
		et = 3'h0;
		if (iw[24:19] == 6'h1D) begin
			if (!ctrl[1] && (!ctrl[0] && !s[7] || ctrl[0] && s >= 8'h30 && s <= 8'h7F))
				et = 3'h2;
			else if (!ok)
				et = 3'h3;
			else begin
				q.push_back({iw[29:25], 24'h0, rdb(ea)});
				mem[ea] = 8'hFF;
			end
		end else if (iw[24:19] == 6'h03) begin
			if (!ctrl[2])
				et = 3'h5;
			else if (iw[25] || !iw[13] && iw[12:5] != 8'h0)
				et = 3'h1;
			else if (ea[2:0] != 3'h0)
				et = 3'h4;
			else begin
				if (iw[29:25] != 5'h0)
					q.push_back({iw[29:25], wd(ea, ctrl[3])});
				q.push_back({iw[29:26], 1'b1, wd(ea + 4, ctrl[3])});
			end
		end
		if (et != 3'h0)
			tcnt++;
		// Status keeps the outcome of the latest accepted instruction, none included
		if (iw[24:19] == 6'h1D || iw[24:19] == 6'h03)
			last = et;
	endtask : predict

	task automatic run(logic [31:0] iw, logic [63:0] a, logic [63:0] b);
		logic [36:0] e;
		predict(iw, a, b);
		seen = 3'h0;
		while (instr_ready !== 1'b1)
			@(posedge clk_sys);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= iw;
		src_a_val <= a;
		src_b_val <= b;
		slow <= r[11];
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		// Trap and write-back pulses stand one cycle, so look just after each edge, the take edge first
		for (int n = 0; n < 30; n++) begin
			#1;
			if (n == 0 && mem_req === 1'b1)
				`CHK({mem_asi, mem_addr}, {xs, xa})
			if (trap_valid === 1'b1) begin
				seen = trap_code;
				break;
			end
			if (wb_valid === 1'b1) begin
				e = (q.size() > 0) ? q.pop_front() : 'x;
				`CHK({wb_reg, wb_data}, {e[36:32], 32'h0, e[31:0]})
				if (q.size() == 0 && instr_ready === 1'b1)
					break;
			end
			@(posedge clk_sys);
		end
		`CHK(seen, et)
		`CHK(q.size(), 0)
		q.delete();
	endtask : run

	initial begin
		repeat (50000) @(posedge clk_sys);
		err_count++;
		complete_run();
	end

	initial begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rq, 32'h4)
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rq, 32'h80)
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		`CHK(re, 1'b1)
		apb(1'b0, 12'h010, 32'h0);
		`CHK({re, rq}, {1'b1, 32'h0})
		for (int k = 0; k < 400; k++) begin
			r = lfsr();
			r2 = lfsr();
			if (k % 20 == 0) begin
				ctrl = {r[3], r[2] | r[5], r[1:0]};
				asi_r = at[(k / 20) % 17];
				apb(1'b1, 12'h000, {28'h0, ctrl});
				apb(1'b1, 12'h004, {24'h0, asi_r});
				apb(1'b0, 12'h000, 32'h0);
				`CHK(rq[3:0], ctrl)
			end
			// Odd subfield every 23rd instruction must be ignored
			run({2'h3, r[6:3], r[7] & r[8], (k % 23 == 0) ? 6'h0D : r[0] ? 6'h1D : 6'h03, r2[9:5], r[9],
				r[9] ? {r2[12:3], r2[2:0] & {3{r[10]}}} : {r[0] ? at[k % 17] : r[10] ? 8'h0 : r2[12:5], r2[4:0]}},
				{56'h0, r[15:11], 3'h0}, {58'h0, r2[15:13], r[10] ? 3'h0 : r2[2:0]});
		end
		apb(1'b0, 12'h008, 32'h0);
		`CHK(rq[8:0], {6'h0, last})
		apb(1'b0, 12'h00C, 32'h0);
		`CHK(rq[15:0], 16'(tcnt))
		complete_run();
	end
endmodule : test_atomic_byte_and_twin_word_load

`default_nettype wire
